// [design/sfe_core.sv]
// serial flash command block: whole erase, deep power-down, identity reads
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - opcodes 60h and C7h both mean whole-array erase, one byte only
// - erase runs only when the write enable latch is set
// - erase only when chip select rises right after the eighth bit
// - erase is self-timed; write-in-progress high while it runs, low after
// - write enable latch cleared during the erase, before it ends
// - erase only when all protect level bits are zero
// - B9h enters deep power-down after the entry delay
// - B9h acts only if chip select rises right after the eighth bit
// - in deep power-down every command but ABh is ignored
// - B9h during a running cycle is rejected, cycle unaffected
// - chip select high alone means standby, never deep power-down
// - power-up always lands in standby
// - ABh alone releases power-down after the first release delay
// - ABh plus three dummy bytes shifts out device identity, MSB first
// - identity byte repeats until chip select rises
// - ABh identity read leaving power-down waits second release delay
// - ABh while write-in-progress is ignored, cycle unaffected
// - 90h plus address zero gives maker then device code, MSB first
// - address 000001h gives device code first
// - 92h gives the same identity over two data lines
module sfe_core
   import sfe_pkg::*;
#(
   parameter logic [7:0] MAKER_ID      = 8'h5A, // arbitrary value
   parameter logic [7:0] DEVICE_ID     = 8'h3C, // arbitrary value
   parameter int         ERASE_TIME_US = 1000,
   parameter int         ERASE_CYC     = ERASE_TIME_US * SFE_CLK_MHZ,
   parameter int         REL1_NS       = 20000,
   parameter int         REL1_CYC      = (REL1_NS * SFE_CLK_MHZ) / 1000,
   parameter int         REL2_NS       = 20000,
   parameter int         REL2_CYC      = (REL2_NS * SFE_CLK_MHZ) / 1000
) (
   input  wire logic       core_clk_i,
   input  wire logic       reset_i,
   input  wire logic       spi_clk_i,
   input  wire logic       cs_n_i,
   input  wire logic       si_i,
   input  wire logic       io1_i,
   output logic            so_o,
   output logic            so_oe_o,
   output logic            io0_o,
   output logic            io0_oe_o,
   input  wire logic [2:0] protect_level_i,
   output logic            write_in_progress_o,
   output logic            write_enable_latch_o,
   output logic            deep_power_down_o,
   output logic            standby_o
);

   localparam int PD_WAIT = SFE_PDOWN_CYC + 1;
   localparam int PD_REST = PD_WAIT - 8;

   // ---------------- link domain (serial clock) ----------------
   logic                 in_frame;
   logic                 frame_tgl;
   logic [SFE_CNT_W-1:0] cnt;
   logic [7:0]           sreg;
   logic [7:0]           opcode;
   logic                 addr0;
   logic                 lk_wip1;
   logic                 lk_wip;
   logic                 lk_quiet1;
   logic                 lk_quiet;
   logic [3:0]           ocnt;
   logic                 so_q;
   logic                 so_oe;
   logic                 io0_q;
   logic                 io0_oe;
   logic                 rd_single;
   logic                 rd_dual;
   logic [7:0]           byte_single;
   logic [7:0]           byte_dual;
   logic [2:0]           bit_single;
   logic [2:0]           bit_dual_hi;
   logic [2:0]           bit_dual_lo;

   // cleared whenever chip select is high
   always_ff @(posedge spi_clk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         in_frame <= 1'b0;
      end else begin
         in_frame <= 1'b1;
      end
   end

   // one toggle per frame tells the core that bits arrived
   always_ff @(posedge spi_clk_i or posedge reset_i) begin
      if (reset_i) begin
         frame_tgl <= 1'b0;
      end else if (!in_frame) begin
         frame_tgl <= ~frame_tgl;
      end
   end

   // bit counter holds its value after the frame for the core to read
   always_ff @(posedge spi_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt <= '0;
      end else if (!in_frame) begin
         cnt <= 6'h01;
      end else if (cnt != SFE_CNT_MAX) begin
         cnt <= cnt + 6'h01;
      end
   end

   // serial input, MSB first
   always_ff @(posedge spi_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sreg   <= 8'h00;
         opcode <= 8'h00;
         addr0  <= 1'b0;
      end else begin
         sreg <= {sreg[6:0], si_i};
         if (in_frame && cnt == SFE_OP_LAST) begin
            opcode <= {sreg[6:0], si_i};
         end
         if (!in_frame) begin
            addr0 <= 1'b0;
         end else if (opcode == SFE_OP_MDID && cnt == SFE_ADDR_LAST1) begin
            addr0 <= si_i;
         end else if (opcode == SFE_OP_MDID2 && cnt == SFE_ADDR_LAST2) begin
            addr0 <= si_i;
         end
      end
   end

   // core state levels into the link domain
   always_ff @(posedge spi_clk_i or posedge reset_i) begin
      if (reset_i) begin
         lk_wip1   <= 1'b0;
         lk_wip    <= 1'b0;
         lk_quiet1 <= 1'b0;
         lk_quiet  <= 1'b0;
      end else begin
         lk_wip1   <= write_in_progress_o;
         lk_wip    <= lk_wip1;
         lk_quiet1 <= !standby_o && !write_in_progress_o;
         lk_quiet  <= lk_quiet1;
      end
   end

   always_comb begin
      rd_single = in_frame && cnt >= SFE_OUT_START1 &&
                  ((opcode == SFE_OP_RELID && !lk_wip) ||
                   (opcode == SFE_OP_MDID && !lk_quiet));
      rd_dual   = in_frame && cnt >= SFE_OUT_START2 &&
                  opcode == SFE_OP_MDID2 && !lk_quiet;
      if (opcode == SFE_OP_RELID) begin
         byte_single = DEVICE_ID;
      end else if (ocnt[3] ^ addr0) begin
         byte_single = DEVICE_ID;
      end else begin
         byte_single = MAKER_ID;
      end
      byte_dual   = (ocnt[2] ^ addr0) ? DEVICE_ID : MAKER_ID;
      bit_single  = ~ocnt[2:0];
      bit_dual_hi = {~ocnt[1:0], 1'b1};
      bit_dual_lo = {~ocnt[1:0], 1'b0};
   end

   // output bits change on the falling serial clock edge
   always_ff @(negedge spi_clk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         ocnt   <= 4'h0;
         so_q   <= 1'b0;
         so_oe  <= 1'b0;
         io0_q  <= 1'b0;
         io0_oe <= 1'b0;
      end else if (rd_single) begin
         ocnt   <= ocnt + 4'h1;
         so_q   <= byte_single[bit_single];
         so_oe  <= 1'b1;
      end else if (rd_dual) begin
         ocnt   <= ocnt + 4'h1;
         so_q   <= byte_dual[bit_dual_hi];
         so_oe  <= 1'b1;
         io0_q  <= byte_dual[bit_dual_lo];
         io0_oe <= 1'b1;
      end
   end

   assign so_o     = so_q;
   assign so_oe_o  = so_oe;
   assign io0_o    = io0_q;
   assign io0_oe_o = io0_oe;

   // ---------------- core domain ----------------
   sfe_state_t state;
   logic [31:0] dly;
   logic        write_enable_latch;
   logic        cs1;
   logic        cs2;
   logic        cs3;
   logic        cs_st;
   logic        t1;
   logic        t2;
   logic        t3;
   logic        seen;
   logic        cs_rise;
   logic        fresh;
   logic        len8;
   logic        in_stby;
   logic        go_write_enable_command;
   logic        go_erase;
   logic        go_pd;
   logic        go_rel1;
   logic        go_rel2;

   // chip select and frame toggle through three flops each
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         cs1   <= 1'b1;
         cs2   <= 1'b1;
         cs3   <= 1'b1;
         cs_st <= 1'b1;
         t1    <= 1'b0;
         t2    <= 1'b0;
         t3    <= 1'b0;
         seen  <= 1'b0;
      end else begin
         cs1 <= cs_n_i;
         cs2 <= cs1;
         cs3 <= cs2;
         if (cs2 == cs3) begin
            cs_st <= cs3;
         end
         t1 <= frame_tgl;
         t2 <= t1;
         t3 <= t2;
         if (cs_rise) begin
            seen <= t3;
         end
      end
   end

   // counter and opcode are static while the serial clock is stopped
   always_comb begin
      cs_rise  = cs2 && cs3 && !cs_st;
      fresh    = (t2 == t3) && (t3 != seen);
      len8     = fresh && cnt == SFE_CMD_BITS;
      in_stby  = state == SFE_ST_STANDBY;
      go_write_enable_command  = cs_rise && len8 && in_stby && opcode == SFE_OP_WRITE_ENABLE_COMMAND;
      go_erase = cs_rise && len8 && in_stby && write_enable_latch &&
                 protect_level_i == SFE_PROT_NONE &&
                 (opcode == SFE_OP_ERASE_A ||
                  opcode == SFE_OP_ERASE_B);
      go_pd    = cs_rise && len8 && in_stby &&
                 opcode == SFE_OP_PDOWN;
      go_rel1  = cs_rise && len8 && state == SFE_ST_PD &&
                 opcode == SFE_OP_RELID;
      go_rel2  = cs_rise && fresh && cnt >= SFE_OUT_START1 &&
                 state == SFE_ST_PD && opcode == SFE_OP_RELID;
   end

   // mode sequencing; only these paths leave standby
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state <= SFE_ST_STANDBY;
         dly   <= 32'h0;
      end else begin
         case (state)
            SFE_ST_STANDBY: begin
               if (go_erase) begin
                  state <= SFE_ST_ERASE;
                  dly   <= 32'(ERASE_CYC - 1);
               end else if (go_pd) begin
                  state <= SFE_ST_PD_ENTER;
                  dly   <= 32'(SFE_PDOWN_CYC - 1);
               end
            end
            SFE_ST_ERASE: begin
               if (dly == 32'h0) begin
                  state <= SFE_ST_STANDBY;
               end else begin
                  dly <= dly - 32'h1;
               end
            end
            SFE_ST_PD_ENTER: begin
               if (dly == 32'h0) begin
                  state <= SFE_ST_PD;
               end else begin
                  dly <= dly - 32'h1;
               end
            end
            SFE_ST_PD: begin
               if (go_rel2) begin
                  state <= SFE_ST_RELEASE;
                  dly   <= 32'(REL2_CYC - 1);
               end else if (go_rel1) begin
                  state <= SFE_ST_RELEASE;
                  dly   <= 32'(REL1_CYC - 1);
               end
            end
            SFE_ST_RELEASE: begin
               if (dly == 32'h0) begin
                  state <= SFE_ST_STANDBY;
               end else begin
                  dly <= dly - 32'h1;
               end
            end
            default: begin
               state <= SFE_ST_STANDBY;
            end
         endcase
      end
   end

   // write enable latch
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         write_enable_latch <= 1'b0;
      end else if (state == SFE_ST_ERASE) begin
         write_enable_latch <= 1'b0;
      end else if (go_write_enable_command) begin
         write_enable_latch <= 1'b1;
      end
   end

   assign write_in_progress_o  = state == SFE_ST_ERASE;
   assign write_enable_latch_o = write_enable_latch;
   assign deep_power_down_o    = state == SFE_ST_PD;
   assign standby_o            = state == SFE_ST_STANDBY;

   // ---------------- checks ----------------
   AST_ERASE_NEEDS_WEL: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      $rose(write_in_progress_o) |-> $past(write_enable_latch))
      else $error("erase started without write enable latch");

   AST_ERASE_PROTECT: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      $rose(write_in_progress_o) |->
         $past(protect_level_i) == SFE_PROT_NONE)
      else $error("erase started with protection set");

   AST_ERASE_EIGHT: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      $rose(write_in_progress_o) |-> $past(cs_rise) && $past(len8))
      else $error("erase started without an eight bit frame");

   AST_WEL_CLEARED: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      $fell(write_in_progress_o) |-> !write_enable_latch && !$past(write_enable_latch))
      else $error("write enable latch still set at erase end");

   AST_PD_DELAY: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      go_pd |=> !deep_power_down_o [*8] ##[PD_REST:PD_REST]
                deep_power_down_o)
      else $error("power-down entry delay wrong");

   AST_PD_HOLDS: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      deep_power_down_o && !go_rel1 && !go_rel2 |=> deep_power_down_o)
      else $error("power-down left without release command");

   AST_BUSY_KEEPS: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      write_in_progress_o && dly != 32'h0 |=> write_in_progress_o)
      else $error("running erase disturbed");

   AST_RELEASE_WAIT: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      $rose(standby_o) && $past(state) == SFE_ST_RELEASE |->
         $past(dly) == 32'h0)
      else $error("release delay cut short");

   AST_STBY_AFTER_RESET: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      $past(reset_i) |-> standby_o && !deep_power_down_o && !write_enable_latch)
      else $error("not in standby after reset");

   AST_WRITE_ENABLE_COMMAND_SETS: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      go_write_enable_command |=> write_enable_latch)
      else $error("write enable command did not set latch");

endmodule

`default_nettype wire

// [design/sfe_pkg.sv]
// constants for the serial flash erase, power-down and identity block
package sfe_pkg;

   // opcodes
   localparam logic [7:0] SFE_OP_WRITE_ENABLE_COMMAND    = 8'h06;
   localparam logic [7:0] SFE_OP_ERASE_A = 8'h60;
   localparam logic [7:0] SFE_OP_ERASE_B = 8'hC7;
   localparam logic [7:0] SFE_OP_PDOWN   = 8'hB9;
   localparam logic [7:0] SFE_OP_RELID   = 8'hAB;
   localparam logic [7:0] SFE_OP_MDID    = 8'h90;
   localparam logic [7:0] SFE_OP_MDID2   = 8'h92;

   // link frame layout, counted in rising serial clock edges
   localparam int         SFE_CNT_W       = 6;
   localparam logic [5:0] SFE_CNT_MAX     = 6'h3F;
   localparam logic [5:0] SFE_OP_LAST     = 6'h07;
   localparam logic [5:0] SFE_CMD_BITS    = 6'h08;
   localparam logic [5:0] SFE_ADDR_LAST1  = 6'h1F;
   localparam logic [5:0] SFE_ADDR_LAST2  = 6'h13;
   localparam logic [5:0] SFE_OUT_START1  = 6'h20;
   localparam logic [5:0] SFE_OUT_START2  = 6'h14;

   // core clock and timing
   localparam int SFE_CLK_MHZ   = 250;
   localparam int SFE_PDOWN_NS  = 3000;
   localparam int SFE_PDOWN_CYC = (SFE_PDOWN_NS * SFE_CLK_MHZ) / 1000;

   // protect level that allows erase
   localparam logic [2:0] SFE_PROT_NONE = 3'h0;

   typedef enum logic [2:0] {
      SFE_ST_STANDBY,
      SFE_ST_ERASE,
      SFE_ST_PD_ENTER,
      SFE_ST_PD,
      SFE_ST_RELEASE
   } sfe_state_t;

endpackage

// [test/sfe_host_model.sv]
// host-side serial bus controller model driving chip select and clock
`timescale 1ns/100ps
`default_nettype none
module sfe_host_model (
   output var logic spi_clk_o,
   output var logic cs_n_o,
   output var logic si_o,
   output var logic io1_o,
   input  wire logic so_i,
   input  wire logic so_oe_i,
   input  wire logic io0_i,
   input  wire logic io0_oe_i
);
   localparam realtime HALF = 7.5;

   initial begin
      spi_clk_o = 1'b0;
      // non-blocking so the block sees the deselect edge
      cs_n_o <= 1'b1;
      si_o = 1'b0;
      io1_o = 1'b1;
   end

   // one framed command; clock idles low between frames
   task automatic frame(input logic [7:0] op, input logic [23:0] adr,
      input int nadr, input bit dual, input int nout,
      output logic [15:0] rx, output logic oe_seen);
      logic [31:0] tx;
      int          nin;
      logic        so_b;
      logic        io0_b;
      tx = {op, adr};
      nin = dual ? 20 : 8 + nadr;
      rx = 16'h0000;
      oe_seen = 1'b0;
      cs_n_o = 1'b0;
      #(HALF);
      for (int i = 0; i < nin + nout; i++) begin
         if (i < 8 || (!dual && i < nin))
            si_o = tx[31 - i];
         else if (i < nin) begin
            io1_o = tx[23 - 2 * (i - 8)];
            si_o = tx[22 - 2 * (i - 8)];
         end else begin
            // released lines keep toggling so stale data never matches
            si_o = ~si_o;
            io1_o = ~io1_o;
         end
         #(HALF);
         spi_clk_o = 1'b1;
         // a released line reads back inverted, so stale bits never match
         so_b = so_oe_i ? so_i : ~so_i;
         io0_b = io0_oe_i ? io0_i : ~io0_i;
         if (i >= nin)
            rx = dual ? {rx[13:0], so_b, io0_b} : {rx[14:0], so_b};
         oe_seen = oe_seen | so_oe_i | io0_oe_i;
         #(HALF);
         spi_clk_o = 1'b0;
      end
      #(HALF);
      cs_n_o = 1'b1;
      si_o = ~si_o;
      io1_o = ~io1_o;
   endtask
endmodule
`default_nettype wire

// [test/serial_flash_erase_powerdown_id_bench.sv]
// self-checking bench for the serial flash command block
`timescale 1ns/100ps
`default_nettype none
module serial_flash_erase_powerdown_id_bench import sfe_pkg::*;;
   localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
   localparam logic [7:0] DEVID = 8'h3C; // arbitrary value

   logic        core_clk;
   logic        reset;
   logic        spi_clk;
   logic        cs_n;
   logic        si;
   logic        io1;
   logic        so;
   logic        so_oe;
   logic        io0;
   logic        io0_oe;
   logic [2:0]  prot;
   logic        write_in_progress;
   logic        write_enable_latch;
   logic        dpd;
   logic        stby;
   logic [15:0] rx;
   logic        oe;
   int          errors;
   int          num_checks;
   int          cycles;

   sfe_host_model host (
      .spi_clk_o (spi_clk),
      .cs_n_o    (cs_n),
      .si_o      (si),
      .io1_o     (io1),
      .so_i      (so),
      .so_oe_i   (so_oe),
      .io0_i     (io0),
      .io0_oe_i  (io0_oe)
   );

   sfe_core #(
      .MAKER_ID  (MAKER),
      .DEVICE_ID (DEVID),
      .ERASE_CYC (400),
      .REL1_CYC  (40),
      .REL2_CYC  (40)
   ) DUT (
      .core_clk_i           (core_clk),
      .reset_i              (reset),
      .spi_clk_i            (spi_clk),
      .cs_n_i               (cs_n),
      .si_i                 (si),
      .io1_i                (io1),
      .so_o                 (so),
      .so_oe_o              (so_oe),
      .io0_o                (io0),
      .io0_oe_o             (io0_oe),
      .protect_level_i      (prot),
      .write_in_progress_o  (write_in_progress),
      .write_enable_latch_o (write_enable_latch),
      .deep_power_down_o    (dpd),
      .standby_o            (stby)
   );

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         wrap_up;
      end
   end

   task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // bounded wait on standby (pd=0) or deep power-down (pd=1)
   task automatic wait_for(input bit pd, input int lim);
      int n;
      n = 0;
      while ((pd ? dpd : stby) !== 1'b1 && n < lim) begin
         @(posedge core_clk);
         n++;
      end
      check("wait", {15'h0, n < lim}, 16'h1);
   endtask

   // frame, then let the synchroniser and decode settle
   task automatic cmd(input logic [7:0] op, input logic [23:0] a,
      input int na, input bit dual, input int nout);
      host.frame(op, a, na, dual, nout, rx, oe);
      repeat (10) @(posedge core_clk);
   endtask

   initial begin
      // non-blocking so the link flops see a clean reset edge
      reset <= 1'b1;
      prot = 3'h0;
      errors = 0;
      num_checks = 0;
      cycles = 0;
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      repeat (6) @(posedge core_clk);
      check("standby", stby, 16'h1);
      check("powerdown", dpd, 16'h0);
      cmd(SFE_OP_ERASE_A, 24'h0, 0, 0, 0);
      check("erase no latch", write_in_progress, 16'h0);
      cmd(SFE_OP_WRITE_ENABLE_COMMAND, 24'h0, 0, 0, 0);
      check("latch", write_enable_latch, 16'h1);
      for (int p = 1; p < 8; p++) begin
         prot <= p[2:0];
         cmd(SFE_OP_ERASE_B, 24'h0, 0, 0, 0);
         check("erase protected", write_in_progress, 16'h0);
         check("latch kept", write_enable_latch, 16'h1);
      end
      prot <= 3'h0;
      cmd(SFE_OP_ERASE_B, 24'h0, 1, 0, 0);
      check("erase nine bits", write_in_progress, 16'h0);
      for (int k = 0; k < 2; k++) begin
         cmd(SFE_OP_WRITE_ENABLE_COMMAND, 24'h0, 0, 0, 0);
         cmd(k ? SFE_OP_ERASE_B : SFE_OP_ERASE_A, 24'h0, 0, 0, 0);
         check("erase busy", write_in_progress, 16'h1);
         check("erase standby", stby, 16'h0);
         check("latch cleared", write_enable_latch, 16'h0);
         cmd(k ? SFE_OP_RELID : SFE_OP_PDOWN, 24'h0, k ? 24 : 0, 0, k * 8);
         check("busy no output", oe, 16'h0);
         check("still busy", write_in_progress, 16'h1);
         wait_for(0, 600);
         check("erase done", write_in_progress, 16'h0);
         check("no powerdown", dpd, 16'h0);
      end
      cmd(SFE_OP_MDID, 24'h0, 24, 0, 16);
      check("id single a0", rx, {MAKER, DEVID});
      cmd(SFE_OP_MDID, 24'h1, 24, 0, 16);
      check("id single a1", rx, {DEVID, MAKER});
      cmd(SFE_OP_MDID2, 24'h0, 24, 1, 8);
      check("id dual a0", rx, {MAKER, DEVID});
      cmd(SFE_OP_MDID2, 24'h1, 24, 1, 8);
      check("id dual a1", rx, {DEVID, MAKER});
      cmd(SFE_OP_RELID, 24'h0, 24, 0, 16);
      check("device id", rx, {DEVID, DEVID});
      cmd(SFE_OP_PDOWN, 24'h0, 1, 0, 0);
      repeat (800) @(posedge core_clk);
      check("pd nine bits", dpd, 16'h0);
      check("pd nine standby", stby, 16'h1);
      cmd(SFE_OP_PDOWN, 24'h0, 0, 0, 0);
      check("pd entering", stby, 16'h0);
      wait_for(1, 900);
      cmd(SFE_OP_WRITE_ENABLE_COMMAND, 24'h0, 0, 0, 0);
      check("pd latch", write_enable_latch, 16'h0);
      cmd(SFE_OP_MDID, 24'h0, 24, 0, 16);
      check("pd no output", oe, 16'h0);
      check("pd held", dpd, 16'h1);
      cmd(SFE_OP_RELID, 24'h0, 0, 0, 0);
      check("released", dpd, 16'h0);
      check("release wait", stby, 16'h0);
      wait_for(0, 200);
      cmd(SFE_OP_PDOWN, 24'h0, 0, 0, 0);
      wait_for(1, 900);
      cmd(SFE_OP_RELID, 24'h0, 24, 0, 8);
      check("release id", rx[7:0], DEVID);
      check("release2 wait", stby, 16'h0);
      wait_for(0, 200);
      wrap_up;
   end
endmodule
`default_nettype wire
